// ==== logic/slf_pkg.sv ====
// ============================================================
// Shared constants and carriers for the supply and load fault logic.
package slf_pkg;

  // ============================================================
  // Sizes.
  localparam int NCH = 4;                  // Number of switched outputs.
  localparam int SYNC_W = 17;              // Width of the asynchronous input bundle.
  localparam int FLT_W = 5;                // Width of the fault and interrupt layout.

  // ============================================================
  // Register byte addresses on the Avalon-MM slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;      // Output command and disable bits.
  localparam logic [7:0] ADDR_FAULT = 8'h04;     // Fault flags, cleared by reading.
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;  // Sticky event bits, write one to clear.
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;  // Interrupt enables, same layout.
  localparam logic [7:0] ADDR_STATE = 8'h10;     // Live output, pin and latch state.

  // ============================================================
  // Field positions.
  localparam int CTRL_CMD_LSB = 0;         // Four output command bits.
  localparam int CTRL_UVDIS_BIT = 4;       // Undervoltage protection disable.
  localparam int CTRL_OLDIS_BIT = 5;       // Open-load detection disable.
  localparam int FLT_UV_BIT = 0;           // Undervoltage flag or event.
  localparam int FLT_OL_LSB = 1;           // Four open-load flags or events.
  localparam int STATE_OUT_LSB = 0;        // Four output states.
  localparam int STATE_FS_BIT = 4;         // Fault status pin level.
  localparam int STATE_LATCH_LSB = 5;      // Four undervoltage latches.

  // ============================================================
  // Reset values.
  localparam logic [FLT_W-1:0] FLT_RST = 5'h00;     // No fault after reset.
  localparam logic [NCH-1:0] CH_RST = 4'h0;         // Channels off after reset.
  localparam logic [31:0] RDATA_RST = 32'h00000000; // Idle read data.

  // Control register contents.
  typedef struct packed {
    logic open_load_disable;               // Open-load detection disabled.
    logic undervolt_protect_disable;               // Undervoltage protection disabled.
    logic [NCH-1:0] cmd;        // Serial output command, one bit per channel.
  } slf_ctrl_t;

  localparam slf_ctrl_t CTRL_RST = '{open_load_disable: 1'b0, undervolt_protect_disable: 1'b0, cmd: 4'h0};

  // Comparator and pin inputs, all asynchronous to clk.
  typedef struct packed {
    logic logic_ok;             // Logic supply within nominal range.
    logic gnd_lost;             // Ground disconnect detected.
    logic below_2v5;            // Battery below 2.5 V.
    logic below_por;            // Battery below battery_por_threshold.
    logic below_uv;             // Battery below battery_uv_threshold.
    logic [NCH-1:0] gate_low;   // Gate drive low enough to turn the output off.
    logic [NCH-1:0] open_load;  // Open-load comparator per channel.
    logic [NCH-1:0] direct_in;  // Direct switch-on inputs.
  } slf_analog_t;

endpackage : slf_pkg

// ==== logic/slf_sync.sv ====
`timescale 1ns/10ps
// ============================================================
// Three-stage synchroniser with agreement filter.
module slf_sync
  import slf_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;    // First stage, read only by the second.
  logic [W-1:0] s2_reg;    // Second stage.
  logic [W-1:0] s3_reg;    // Third stage.
  logic [W-1:0] out_reg;   // Accepted value.
  logic [W-1:0] out_next;  // Next accepted value.

  // ============================================================
  // A bit only moves when stages two and three agree, so a single metastable sample never reaches the logic.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // Registers for the chain and the accepted value.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

  // Output only follows a value both later stages have held.
  a_sync_agree: assert property (@(posedge clk) disable iff (!rst_n)
    (out_reg != $past(out_reg)) |-> (out_reg == $past(s3_reg)))
    else $error("sync output moved without agreement");

endmodule : slf_sync

// ==== logic/slf_open_load.sv ====
`timescale 1ns/10ps
// ============================================================
// One channel of open-load flag capture.
module slf_open_load
  import slf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_open,
  input wire logic gate_low,
  input wire logic output_on,
  input wire logic detect_disable,
  input wire logic read_clear,
  output logic fault_present,
  output logic open_load_flag
);

  logic flag_reg;   // Captured open-load flag.
  logic flag_next;  // Next flag value.
  logic cond;       // Open load seen on a switched-off channel.
  logic set;        // Capture request.

  // ============================================================
  // The flag is only judged with the channel off and its gate pulled down; a read clears it only while that open-load condition is absent.
  always_comb
  begin
    cond = load_open && !output_on && gate_low;
    set = cond && !detect_disable;
    flag_next = flag_reg;
    if (read_clear && !cond)
    begin
      flag_next = 1'b0;
    end
    if (set)
    begin
      flag_next = 1'b1; // Set wins over a clear in the same cycle.
    end
  end

  // Flag register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign fault_present = set;
  assign open_load_flag = flag_reg;

  a_ol_when_off: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flag_reg) |-> $past(!output_on && gate_low && !detect_disable))
    else $error("open-load flag rose while channel on or detection disabled");

  a_ol_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (read_clear && !load_open) |=> !flag_reg)
    else $error("open-load flag not cleared by read");

endmodule : slf_open_load

// ==== logic/slf_fault_logic.sv ====
`timescale 1ns/10ps
// ============================================================
// Supply and load fault logic: undervoltage, open load, ground loss, register slave and interrupt.
module slf_fault_logic
  import slf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire slf_analog_t analog_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NCH-1:0] output_on,
  output logic fault_status_n,
  output logic daisy_enable,
  output logic irq
);

  // ============================================================
  // Declarations.
  logic [SYNC_W-1:0] sync_bits;          // Synchronised input bundle.
  slf_analog_t syn;                      // Same bundle, by field.
  slf_ctrl_t ctrl_reg;                   // Control register.
  slf_ctrl_t ctrl_next;
  logic uv_flag_reg;                     // undervolt_flag.
  logic uv_flag_next;
  logic uv_prev_reg;                     // Undervoltage level one cycle ago, for events.
  logic uv_prev_next;
  logic [NCH-1:0] latch_reg;             // Per-channel latched undervoltage.
  logic [NCH-1:0] latch_next;
  logic [NCH-1:0] cmd_prev_reg;          // Command one cycle ago, for switch-on edges.
  logic [NCH-1:0] cmd_prev_next;
  logic [NCH-1:0] out_reg;               // Output drive.
  logic [NCH-1:0] out_next;
  logic fs_n_reg;                        // fault_status_n pin.
  logic fs_n_next;
  logic daisy_reg;                       // Daisy chain enable.
  logic daisy_next;
  logic [FLT_W-1:0] irq_stat_reg;        // Sticky event bits.
  logic [FLT_W-1:0] irq_stat_next;
  logic [FLT_W-1:0] irq_mask_reg;        // Interrupt enables.
  logic [FLT_W-1:0] irq_mask_next;
  logic irq_reg;                         // Interrupt output.
  logic irq_next;
  logic wait_reg;                        // avs_waitrequest.
  logic wait_next;
  logic [31:0] rdata_reg;                // avs_readdata.
  logic [31:0] rdata_next;
  logic [NCH-1:0] cmd;                   // Combined serial and direct command.
  logic [NCH-1:0] cmd_rise;              // New switch-on command.
  logic [NCH-1:0] open_load_flag;        // Per-channel open-load flags.
  logic [NCH-1:0] ol_present;            // Live open-load report.
  logic [NCH-1:0] ol_clear;              // Read-clear per channel.
  logic uv_protect;                      // Undervoltage acting on outputs.
  logic uv_pin;                          // Undervoltage reported on the pin.
  logic accept;                          // Bus access completes this edge.
  logic fault_read;                      // Fault register read completes.
  logic [FLT_W-1:0] events;              // Event pulses for the interrupt status.

  // Decodes a byte address into the register read value.
  function automatic logic [31:0] read_mux(input logic [7:0] addr, input slf_ctrl_t c,
                                           input logic [FLT_W-1:0] flt, input logic [FLT_W-1:0] st,
                                           input logic [FLT_W-1:0] mk, input logic [NCH-1:0] o,
                                           input logic fs, input logic [NCH-1:0] lt);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr)
      ADDR_CTRL: v[5:0] = c;
      ADDR_FAULT: v[FLT_W-1:0] = flt;
      ADDR_IRQ_STAT: v[FLT_W-1:0] = st;
      ADDR_IRQ_MASK: v[FLT_W-1:0] = mk;
      ADDR_STATE:
      begin
        v[STATE_OUT_LSB +: NCH] = o;
        v[STATE_FS_BIT] = fs;
        v[STATE_LATCH_LSB +: NCH] = lt;
      end
      default: v = 32'h00000000; // Unmapped addresses read as zero.
    endcase
    return v;
  endfunction : read_mux

  // ============================================================
  // Input synchronisation.
  slf_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(analog_in),
    .sync_out(sync_bits)
  );

  assign syn = slf_analog_t'(sync_bits);

  // ============================================================
  // Open-load channels; the flag is only evaluated against the registered output state.
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ol
      slf_open_load u_ol (
        .clk(clk),
        .rst_n(rst_n),
        .load_open(syn.open_load[g]),
        .gate_low(syn.gate_low[g]),
        .output_on(out_reg[g]),
        .detect_disable(ctrl_reg.open_load_disable),
        .read_clear(ol_clear[g]),
        .fault_present(ol_present[g]),
        .open_load_flag(open_load_flag[g])
      );
    end
  endgenerate

  // ============================================================
  // Bus decode: one wait cycle, then the access completes at the edge where waitrequest is low.
  always_comb
  begin
    accept = (avs_read || avs_write) && !wait_reg;
    fault_read = accept && avs_read && (avs_address == ADDR_FAULT);
    // Only bits that were actually returned are cleared, so nothing set after the sample is lost.
    ol_clear = fault_read ? rdata_reg[FLT_OL_LSB +: NCH] : CH_RST;
    wait_next = !((avs_read || avs_write) && wait_reg);
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg)
    begin
      rdata_next = read_mux(avs_address, ctrl_reg, {open_load_flag, uv_flag_reg}, irq_stat_reg,
                            irq_mask_reg, out_reg, fs_n_reg, latch_reg);
    end
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    if (accept && avs_write && (avs_address == ADDR_CTRL))
    begin
      ctrl_next = slf_ctrl_t'(avs_writedata[5:0]);
    end
    if (accept && avs_write && (avs_address == ADDR_IRQ_MASK))
    begin
      irq_mask_next = avs_writedata[FLT_W-1:0];
    end
  end

  // ============================================================
  // Undervoltage, ground loss and output control.
  always_comb
  begin
    cmd = ctrl_reg.cmd | syn.direct_in;
    cmd_rise = cmd & ~cmd_prev_reg;
    cmd_prev_next = cmd;
    uv_protect = syn.below_uv && !ctrl_reg.undervolt_protect_disable;
    // Below the reset threshold the pin is released even though outputs stay off.
    uv_pin = uv_protect && !syn.below_por;
    uv_prev_next = syn.below_uv;
    // A new switch-on clears a latch; a latch sets only for channels commanded on.
    latch_next = latch_reg & ~cmd_rise;
    if (uv_protect)
    begin
      latch_next = latch_next | cmd;
    end
    for (int i = 0; i < NCH; i++)
    begin
      out_next[i] = cmd[i] && !uv_protect && !latch_next[i] && !syn.below_2v5 && !syn.gnd_lost;
    end
    fs_n_next = !(uv_pin || (|latch_reg) || (|ol_present));
    // The flag is set at every level below the threshold and only a read of a returned one clears it.
    uv_flag_next = uv_flag_reg;
    if (fault_read && rdata_reg[FLT_UV_BIT])
    begin
      uv_flag_next = 1'b0;
    end
    if (syn.below_uv)
    begin
      uv_flag_next = 1'b1;
    end
    daisy_next = syn.logic_ok;
  end

  // ============================================================
  // Interrupt status, write one to clear; a new event beats the clear.
  always_comb
  begin
    events = {ol_present & ~open_load_flag, syn.below_uv && !uv_prev_reg};
    irq_stat_next = irq_stat_reg;
    if (accept && avs_write && (avs_address == ADDR_IRQ_STAT))
    begin
      irq_stat_next = irq_stat_reg & ~avs_writedata[FLT_W-1:0];
    end
    irq_stat_next = irq_stat_next | events;
    irq_next = |(irq_stat_reg & irq_mask_reg);
  end

  // ============================================================
  // State registers; only rst_n resets them, a low battery never does.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RST;
      uv_flag_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
      latch_reg <= CH_RST;
      cmd_prev_reg <= CH_RST;
      out_reg <= CH_RST;
      fs_n_reg <= 1'b1;
      daisy_reg <= 1'b0;
      irq_stat_reg <= FLT_RST;
      irq_mask_reg <= FLT_RST;
      irq_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= RDATA_RST;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      uv_flag_reg <= uv_flag_next;
      uv_prev_reg <= uv_prev_next;
      latch_reg <= latch_next;
      cmd_prev_reg <= cmd_prev_next;
      out_reg <= out_next;
      fs_n_reg <= fs_n_next;
      daisy_reg <= daisy_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign output_on = out_reg;
  assign fault_status_n = fs_n_reg;
  assign daisy_enable = daisy_reg;
  assign irq = irq_reg;

  // ============================================================
  // Checks.
  a_uv_output_off: assert property (@(posedge clk) disable iff (!rst_n)
    uv_protect |=> (out_reg == CH_RST))
    else $error("output on during undervoltage");

  a_uv_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
    uv_pin |=> !fs_n_reg)
    else $error("fault pin high during undervoltage");

  // Below the reset threshold nothing but a latch or an open load may hold the pin low.
  a_por_pin_free: assert property (@(posedge clk) disable iff (!rst_n)
    (syn.below_por && (latch_reg == CH_RST) && (ol_present == CH_RST)) |=> fs_n_reg)
    else $error("fault pin held low below the reset threshold");

  a_uv_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (uv_flag_reg && !fault_read) |=> uv_flag_reg)
    else $error("undervolt flag dropped without a read");

  a_uv_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    syn.below_uv |=> uv_flag_reg)
    else $error("undervolt flag not set");

  a_uv_disable_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_reg.undervolt_protect_disable && !syn.below_2v5 && !syn.gnd_lost && (latch_reg == CH_RST)) |=> (out_reg == $past(cmd)))
    else $error("output changed with protection disabled");

  a_latch_on_only: assert property (@(posedge clk) disable iff (!rst_n)
    (uv_protect && (cmd == CH_RST) && (latch_reg == CH_RST)) |=> (latch_reg == CH_RST))
    else $error("undervoltage latched with all outputs off");

  a_latch_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_reg != CH_RST) |=> !fs_n_reg)
    else $error("fault pin released while latched");

  a_gnd_off: assert property (@(posedge clk) disable iff (!rst_n)
    syn.gnd_lost |=> (out_reg == CH_RST))
    else $error("output on after ground loss");

  a_daisy_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (daisy_reg == $past(syn.logic_ok)))
    else $error("daisy enable not following logic supply");

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
    ((avs_read || avs_write) && wait_reg) |=> !wait_reg)
    else $error("bus access not answered after one wait cycle");

endmodule : slf_fault_logic

// ==== test/slf_host_model.sv ====
`timescale 1ns/10ps
// ============================================================
// Host model: the microcontroller that reads fault status over Avalon-MM.
module slf_host_model
  import slf_pkg::*;
(
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  // The bus is idle from time zero so the slave never sees an unknown request.
  initial
  begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end

  // One access: the request is held until waitrequest is sampled low, then released.
  // A trailing idle edge keeps two calls from assigning the strobe twice in one time step.
  // The wait is open ended: only the bench watchdog ends an access that is never answered.
  task automatic bus_access(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus_access
endmodule : slf_host_model

// ==== test/slf_fault_logic_test.sv ====
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the supply and load fault logic.
module slf_fault_logic_test
  import slf_pkg::*;
;
  logic clk = 1'b0; // 20 MHz system clock.
  logic rst_n = 1'b0; // Active-low reset.
  slf_analog_t ana = '0; // Comparator levels driven by the bench.
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NCH-1:0] output_on;
  logic fault_status_n;
  logic daisy_enable;
  logic irq;
  int num_errors = 0; // Mismatches seen.
  int samples_checked = 0; // Comparisons made.

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  slf_fault_logic u_dut (.clk(clk), .rst_n(rst_n), .analog_in(ana), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .output_on(output_on), .fault_status_n(fault_status_n),
    .daisy_enable(daisy_enable), .irq(irq));

  slf_host_model u_host (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));

  // ============================================================
  // Helpers.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Register write through the host model.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    u_host.bus_access(1'b1, a, d, dummy);
  endtask : wr

  // Register read compared with an expected word.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.bus_access(1'b0, a, 32'h00000000, d);
    check(d, e);
  endtask : rd

  // Waits n clock edges; eight covers the four-edge synchroniser plus the output register.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  // Compares output drive and the fault pin together.
  task automatic pins(input logic [NCH-1:0] o, input logic fs);
    check({27'h0000000, output_on, fault_status_n}, {27'h0000000, o, fs});
  endtask : pins

  // Prints counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Watchdog: the tests need well under 2000 cycles, so 6000 means a hang.
  initial
  begin
    #(6000 * 50);
    num_errors++;
    test_done();
  end

  // ============================================================
  // Main sequence.
  initial
  begin
    ana.logic_ok = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle(8);
    pins(4'h0, 1'b1);
    check({31'h0, daisy_enable}, 32'h1);
    rd(ADDR_CTRL, 32'h0);
    rd(8'h20, 32'h0);
    // Latched undervoltage: output commanded on while the battery sags.
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_CTRL, 32'h5);
    settle(8);
    pins(4'h5, 1'b1);
    ana.below_uv <= 1'b1;
    settle(2);
    pins(4'h5, 1'b1);
    settle(8);
    pins(4'h0, 1'b0);
    check({31'h0, irq}, 32'h1);
    rd(ADDR_FAULT, 32'h1);
    ana.below_uv <= 1'b0;
    settle(8);
    pins(4'h0, 1'b0);
    rd(ADDR_STATE, 32'h000000a0);
    rd(ADDR_FAULT, 32'h1);
    rd(ADDR_FAULT, 32'h0);
    rd(ADDR_CTRL, 32'h5);
    wr(ADDR_IRQ_STAT, 32'h1);
    settle(3);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h5);
    settle(3);
    pins(4'h5, 1'b1);
    // Non-latched undervoltage: everything commanded off.
    wr(ADDR_CTRL, 32'h0);
    ana.below_uv <= 1'b1;
    settle(8);
    pins(4'h0, 1'b0);
    ana.below_por <= 1'b1;
    settle(8);
    pins(4'h0, 1'b1);
    ana.below_por <= 1'b0;
    ana.below_uv <= 1'b0;
    settle(8);
    pins(4'h0, 1'b1);
    rd(ADDR_FAULT, 32'h1);
    rd(ADDR_FAULT, 32'h0);
    // Latch released by a fresh switch-on on the direct input.
    ana.direct_in <= 4'h2;
    settle(8);
    ana.below_uv <= 1'b1;
    settle(8);
    ana.below_uv <= 1'b0;
    settle(8);
    pins(4'h0, 1'b0);
    ana.direct_in <= 4'h0;
    settle(8);
    ana.direct_in <= 4'h2;
    settle(8);
    pins(4'h2, 1'b1);
    ana.direct_in <= 4'h0;
    rd(ADDR_FAULT, 32'h1);
    // Undervoltage protection disabled: flag only, until the 2.5 V floor.
    wr(ADDR_CTRL, 32'h15);
    ana.below_uv <= 1'b1;
    settle(8);
    pins(4'h5, 1'b1);
    rd(ADDR_FAULT, 32'h1);
    ana.below_2v5 <= 1'b1;
    settle(8);
    pins(4'h0, 1'b1);
    ana.below_2v5 <= 1'b0;
    ana.below_uv <= 1'b0;
    settle(8);
    pins(4'h5, 1'b1);
    rd(ADDR_FAULT, 32'h1);
    rd(ADDR_FAULT, 32'h0);
    // Ground loss overrides the command.
    ana.gnd_lost <= 1'b1;
    settle(8);
    pins(4'h0, 1'b1);
    ana.gnd_lost <= 1'b0;
    settle(8);
    pins(4'h5, 1'b1);
    // Open load: captured only with the output off and its gate low.
    wr(ADDR_CTRL, 32'h0);
    ana.open_load <= 4'h1;
    settle(8);
    pins(4'h0, 1'b1);
    rd(ADDR_FAULT, 32'h0);
    ana.gate_low <= 4'h1;
    settle(8);
    pins(4'h0, 1'b0);
    rd(ADDR_FAULT, 32'h2);
    rd(ADDR_FAULT, 32'h2);
    ana.open_load <= 4'h0;
    settle(8);
    pins(4'h0, 1'b1);
    rd(ADDR_FAULT, 32'h2);
    rd(ADDR_FAULT, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    ana.open_load <= 4'h1;
    settle(8);
    pins(4'h1, 1'b1);
    rd(ADDR_FAULT, 32'h0);
    // Host disables detection, as for a load that is permanently missing.
    wr(ADDR_CTRL, 32'h20);
    settle(8);
    pins(4'h0, 1'b1);
    rd(ADDR_FAULT, 32'h0);
    ana.open_load <= 4'h0;
    ana.gate_low <= 4'h0;
    // Logic supply out of range stops the daisy chain.
    ana.logic_ok <= 1'b0;
    settle(8);
    check({31'h0, daisy_enable}, 32'h0);
    rd(ADDR_STATE, 32'h00000010);
    test_done();
  end
endmodule : slf_fault_logic_test
